// ==== rtl/sba_map.svh ====
// Purpose: Offsets, field positions, reset values and timing counts of the serial byte access.
// Assumes: System clock of 50 MHz.
// Notes:   Definitions only.
`ifndef SBA_MAP_SVH
`define SBA_MAP_SVH

// ****************************************
// Register offsets
// ****************************************
`define SBA_OFF_DATA 8'hB0
`define SBA_OFF_WORD 8'hB1
`define SBA_OFF_TARGET 8'hB2
`define SBA_OFF_CSR 8'hB3

// ****************************************
// Fields and reset values
// ****************************************
`define SBA_REG_RESET 8'h00
`define SBA_TGT_DIR_BIT 0
`define SBA_CSR_PROT_BIT 7
`define SBA_CSR_BUSY_BIT 5
`define SBA_CSR_TEST_BIT 2
`define SBA_CSR_ERR_BIT 1

// ****************************************
// Timing
// ****************************************
`define SBA_SYS_CLK_HZ 50000000
`define SBA_SCL_NORM_HZ 60000
`define SBA_SCL_FAST_HZ 4000000
// Quarter periods of the serial clock, rounded down so the bus never runs slow
`define SBA_QTR_NORM (`SBA_SYS_CLK_HZ / (4 * `SBA_SCL_NORM_HZ))
`define SBA_QTR_FAST (`SBA_SYS_CLK_HZ / (4 * `SBA_SCL_FAST_HZ))
`define SBA_LAST_BIT 4'h8

`endif

// ==== rtl/sba_pkg.sv ====
// Purpose: Types of the serial byte access.
// Assumes: Nothing.
// Notes:   Constants live in sba_map.svh.
package sba_pkg;

   typedef enum logic [2:0] {ST_IDLE, ST_START, ST_TX, ST_RX, ST_STOP} sba_state_t;

   typedef enum logic [1:0] {BY_ADDR, BY_WORD, BY_DATA, BY_RADDR} sba_byte_t;

endpackage

// ==== rtl/sba_tick_gen.sv ====
// Purpose: Quarter-period tick for the serial clock.
// Assumes: run is synchronous to clk.
// Notes:   Counter restarts whenever run drops, so the first quarter is full length.
`timescale 1ns/1ps
`default_nettype none

module sba_tick_gen #(
   parameter int unsigned QTR_NORM = 208,
   parameter int unsigned QTR_FAST = 3
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Control
   input wire logic run,
   input wire logic fast,
   // Tick
   output logic tick
);

   localparam logic [15:0] LIM_NORM = 16'(QTR_NORM - 1);
   localparam logic [15:0] LIM_FAST = 16'(QTR_FAST - 1);

   initial begin
      if (QTR_NORM < 2 || QTR_NORM > 65536 || QTR_FAST < 1 || QTR_FAST > QTR_NORM) begin
         $error("sba_tick_gen: quarter counts out of range");
      end
   end

   logic [15:0] cnt;
   logic [15:0] next_cnt;
   logic next_tick;

   always_comb begin
      next_cnt = cnt + 16'h0001;
      next_tick = 1'b0;
      if (!run) begin
         next_cnt = 16'h0000;
      end else if (cnt >= (fast ? LIM_FAST : LIM_NORM)) begin
         next_cnt = 16'h0000;
         next_tick = 1'b1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt <= 16'h0000;
         tick <= 1'b0;
      end else begin
         cnt <= next_cnt;
         tick <= next_tick;
      end
   end

endmodule

`default_nettype wire

// ==== rtl/sba_serial_byte_access.sv ====
// Purpose: Software-launched single-byte two-wire master access behind byte config registers.
// Assumes: RST is the fundamental reset; SCL and SDA are open drain with external pull-ups.
// Notes:   One byte per launch; launches while busy start nothing but still load the target register.
//
// How it works
// - An 8-bit data register holds the byte to send or the byte received.
// - A read deposits the received byte; valid once the busy flag clears.
// - An 8-bit word-address register selects the location inside the target.
// - A write to the target register while idle launches one serial transaction.
// - Target bits 7:1 hold the 7-bit device address, reset zero.
// - Target bit 0 picks direction: zero writes one byte, one reads.
// - Data, word and target registers clear only on the fundamental reset.
// - Busy flag reads one while a launched cycle runs, else zero.
// - Address-phase select zero sends device and word address; one sends device only.
// - A transfer error sets an error flag that a status read clears.
// - Serial clock near 60 kHz normally, near 4 MHz with the test bit.
`timescale 1ns/1ps
`default_nettype none
`include "sba_map.svh"

module sba_serial_byte_access #(
   parameter int unsigned QTR_NORM = `SBA_QTR_NORM,
   parameter int unsigned QTR_FAST = `SBA_QTR_FAST
) (
   // Clock and reset
   input wire logic SYS_CLK,
   input wire logic RST,
   // Config register port
   input wire logic [7:0] CFG_ADDR,
   input wire logic CFG_WR,
   input wire logic CFG_RD,
   input wire logic [7:0] CFG_WDATA,
   output logic [7:0] CFG_RDATA,
   // Serial clock pin
   input wire logic SCL_IN,
   output logic SCL_OUT,
   output logic SCL_OE,
   // Serial data pin
   input wire logic SDA_IN,
   output logic SDA_OUT,
   output logic SDA_OE
);
   import sba_pkg::*;

   // ****************************************
   // State
   // ****************************************
   sba_state_t state, next_state;
   sba_byte_t sel, next_sel;
   logic [1:0] phase, next_phase;
   logic [3:0] bit_cnt, next_bit_cnt;
   logic [7:0] shift, next_shift;
   logic [7:0] serial_byte_buffer, next_serial_byte_buffer;
   logic [7:0] serial_word_location, next_serial_word_location;
   logic [7:0] serial_target_and_direction, next_serial_target_and_direction;
   logic address_phase_select, next_address_phase_select;
   logic fast_clock_test, next_fast_clock_test;
   logic request_in_flight, next_request_in_flight;
   logic transfer_error_flag, next_transfer_error_flag;
   logic nack, next_nack;
   logic [7:0] rdata, next_rdata;
   logic scl_drive, next_scl_drive;
   logic sda_drive, next_sda_drive;
   logic scl_meta, scl_sync, sda_meta, sda_sync;
   logic tick;

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [7:0] csr_value(input logic prot, input logic busy,
                                            input logic test, input logic err);
      logic [7:0] v;
      v = 8'h00;
      v[`SBA_CSR_PROT_BIT] = prot;
      v[`SBA_CSR_BUSY_BIT] = busy;
      v[`SBA_CSR_TEST_BIT] = test;
      v[`SBA_CSR_ERR_BIT] = err;
      return v;
   endfunction

   sba_tick_gen #(
      .QTR_NORM(QTR_NORM),
      .QTR_FAST(QTR_FAST)
   ) u_tick (
      .clk(SYS_CLK),
      .rst(RST),
      .run(request_in_flight),
      .fast(fast_clock_test),
      .tick(tick)
   );

   // ****************************************
   // Next-state logic
   // ****************************************
   always_comb begin
      next_state = state;
      next_sel = sel;
      next_phase = phase;
      next_bit_cnt = bit_cnt;
      next_shift = shift;
      next_serial_byte_buffer = serial_byte_buffer;
      next_serial_word_location = serial_word_location;
      next_serial_target_and_direction = serial_target_and_direction;
      next_address_phase_select = address_phase_select;
      next_fast_clock_test = fast_clock_test;
      next_request_in_flight = request_in_flight;
      next_transfer_error_flag = transfer_error_flag;
      next_nack = nack;
      next_rdata = rdata;
      next_scl_drive = scl_drive;
      next_sda_drive = sda_drive;

      // Register reads
      if (CFG_RD) begin
         case (CFG_ADDR)
            `SBA_OFF_DATA: next_rdata = serial_byte_buffer;
            `SBA_OFF_WORD: next_rdata = serial_word_location;
            `SBA_OFF_TARGET: next_rdata = serial_target_and_direction;
            `SBA_OFF_CSR: begin
               next_rdata = csr_value(address_phase_select, request_in_flight,
                                      fast_clock_test, transfer_error_flag);
               next_transfer_error_flag = 1'b0;
            end
            default: next_rdata = 8'h00;
         endcase
      end

      // Register writes
      if (CFG_WR) begin
         case (CFG_ADDR)
            `SBA_OFF_DATA: next_serial_byte_buffer = CFG_WDATA;
            `SBA_OFF_WORD: next_serial_word_location = CFG_WDATA;
            `SBA_OFF_TARGET: begin
               next_serial_target_and_direction = CFG_WDATA;
               // Relaunch while busy would corrupt the frame, so it is dropped
               if (!request_in_flight) begin
                  next_request_in_flight = 1'b1;
                  next_state = ST_START;
                  next_sel = BY_ADDR;
                  next_phase = 2'h0;
               end
            end
            `SBA_OFF_CSR: begin
               next_address_phase_select = CFG_WDATA[`SBA_CSR_PROT_BIT];
               next_fast_clock_test = CFG_WDATA[`SBA_CSR_TEST_BIT];
            end
            default: ;
         endcase
      end

      // Bit engine, one action per quarter; a slave holding SCL low stretches it
      if (tick && state != ST_IDLE && !(phase == 2'h2 && !scl_sync)) begin
         next_phase = phase + 2'h1;
         case (state)
            ST_START: begin
               case (phase)
                  2'h0: next_sda_drive = 1'b0;
                  2'h1: next_scl_drive = 1'b0;
                  2'h2: next_sda_drive = 1'b1;
                  default: begin
                     next_scl_drive = 1'b1;
                     next_state = ST_TX;
                     next_bit_cnt = 4'h0;
                     // First address byte carries write unless only the device address is sent for a read
                     next_shift = {serial_target_and_direction[7:1],
                                   (sel == BY_RADDR) ? 1'b1 :
                                   (serial_target_and_direction[`SBA_TGT_DIR_BIT] &
                                    address_phase_select)};
                  end
               endcase
            end
            ST_TX: begin
               case (phase)
                  2'h0: begin
                     next_scl_drive = 1'b1;
                     next_sda_drive = (bit_cnt == `SBA_LAST_BIT) ? 1'b0 : ~shift[7];
                  end
                  2'h1: next_scl_drive = 1'b0;
                  2'h2: next_nack = sda_sync;
                  default: begin
                     next_scl_drive = 1'b1;
                     if (bit_cnt != `SBA_LAST_BIT) begin
                        next_bit_cnt = bit_cnt + 4'h1;
                        next_shift = {shift[6:0], 1'b0};
                     end else if (nack) begin
                        next_transfer_error_flag = 1'b1;
                        next_state = ST_STOP;
                     end else begin
                        next_bit_cnt = 4'h0;
                        case (sel)
                           BY_ADDR: begin
                              if (address_phase_select) begin
                                 if (serial_target_and_direction[`SBA_TGT_DIR_BIT]) begin
                                    next_state = ST_RX;
                                 end else begin
                                    next_sel = BY_DATA;
                                    next_shift = serial_byte_buffer;
                                 end
                              end else begin
                                 next_sel = BY_WORD;
                                 next_shift = serial_word_location;
                              end
                           end
                           BY_WORD: begin
                              if (serial_target_and_direction[`SBA_TGT_DIR_BIT]) begin
                                 next_sel = BY_RADDR;
                                 next_state = ST_START;
                              end else begin
                                 next_sel = BY_DATA;
                                 next_shift = serial_byte_buffer;
                              end
                           end
                           BY_RADDR: next_state = ST_RX;
                           default: next_state = ST_STOP;
                        endcase
                     end
                  end
               endcase
            end
            ST_RX: begin
               case (phase)
                  2'h0: begin
                     next_scl_drive = 1'b1;
                     // Bits and the closing not-acknowledge all leave SDA released
                     next_sda_drive = 1'b0;
                  end
                  2'h1: next_scl_drive = 1'b0;
                  2'h2: begin
                     if (bit_cnt != `SBA_LAST_BIT) begin
                        next_shift = {shift[6:0], sda_sync};
                     end
                  end
                  default: begin
                     next_scl_drive = 1'b1;
                     if (bit_cnt != `SBA_LAST_BIT) begin
                        next_bit_cnt = bit_cnt + 4'h1;
                     end else begin
                        next_serial_byte_buffer = shift;
                        next_state = ST_STOP;
                     end
                  end
               endcase
            end
            ST_STOP: begin
               case (phase)
                  2'h0: begin
                     next_scl_drive = 1'b1;
                     next_sda_drive = 1'b1;
                  end
                  2'h1: next_scl_drive = 1'b0;
                  2'h2: next_sda_drive = 1'b0;
                  default: begin
                     next_state = ST_IDLE;
                     next_request_in_flight = 1'b0;
                  end
               endcase
            end
            default: next_state = ST_IDLE;
         endcase
      end
   end

   // ****************************************
   // Registers
   // ****************************************
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         state <= ST_IDLE;
         sel <= BY_ADDR;
         phase <= 2'h0;
         bit_cnt <= 4'h0;
         shift <= `SBA_REG_RESET;
         serial_byte_buffer <= `SBA_REG_RESET;
         serial_word_location <= `SBA_REG_RESET;
         serial_target_and_direction <= `SBA_REG_RESET;
         address_phase_select <= 1'b0;
         fast_clock_test <= 1'b0;
         request_in_flight <= 1'b0;
         transfer_error_flag <= 1'b0;
         nack <= 1'b0;
         rdata <= `SBA_REG_RESET;
         scl_drive <= 1'b0;
         sda_drive <= 1'b0;
         scl_meta <= 1'b1;
         scl_sync <= 1'b1;
         sda_meta <= 1'b1;
         sda_sync <= 1'b1;
      end else begin
         state <= next_state;
         sel <= next_sel;
         phase <= next_phase;
         bit_cnt <= next_bit_cnt;
         shift <= next_shift;
         serial_byte_buffer <= next_serial_byte_buffer;
         serial_word_location <= next_serial_word_location;
         serial_target_and_direction <= next_serial_target_and_direction;
         address_phase_select <= next_address_phase_select;
         fast_clock_test <= next_fast_clock_test;
         request_in_flight <= next_request_in_flight;
         transfer_error_flag <= next_transfer_error_flag;
         nack <= next_nack;
         rdata <= next_rdata;
         scl_drive <= next_scl_drive;
         sda_drive <= next_sda_drive;
         scl_meta <= SCL_IN;
         scl_sync <= scl_meta;
         sda_meta <= SDA_IN;
         sda_sync <= sda_meta;
      end
   end

   // Open drain: the pins are only ever pulled low
   assign CFG_RDATA = rdata;
   assign SCL_OE = scl_drive;
   assign SDA_OE = sda_drive;
   assign SCL_OUT = 1'b0;
   assign SDA_OUT = 1'b0;

endmodule

`default_nettype wire

// ==== test/sba_eeprom_model.sv ====
// Purpose: Behavioural two-wire byte memory at the far end of the serial bus.
// Assumes: Wire levels come from the bench, with pull-ups on both wires.
// Notes:   No clock stretching; the first byte after a write address sets the pointer.
`timescale 1ns/1ps
`default_nettype none
module sba_eeprom_model #(
   parameter logic [6:0] DEV = 7'h2A
) (
   // Wire levels
   input wire logic scl,
   input wire logic sda,
   // Data pull
   output logic sda_oe
);
   logic [7:0] mem [256];
   logic [7:0] sh = 8'h00;
   logic [7:0] ptr = 8'h00;
   logic rd = 1'b0;
   logic on = 1'b0;
   int cnt = 0;
   int idx = 0;
   initial sda_oe = 1'b0;
   // ****************************************
   // Framing and byte handling
   // ****************************************
   always @(negedge sda) begin
      if (scl) begin
         on = 1'b1;
         cnt = 0;
         idx = 0;
      end
   end
   always @(posedge sda) begin
      if (scl) begin
         on = 1'b0;
         sda_oe = 1'b0;
      end
   end
   always @(posedge scl) begin
      if (on && cnt < 8) sh = {sh[6:0], sda};
      if (on) cnt = cnt + 1;
   end
   // Pull changes only while the clock is low, so it never fakes a start or stop
   always @(negedge scl) begin
      if (on && cnt == 8) begin
         if (rd && idx > 0) begin
            sda_oe = 1'b0;
         end else if (idx == 0) begin
            rd = sh[0];
            sda_oe = (sh[7:1] == DEV);
            on = sda_oe;
         end else if (idx == 1) begin
            ptr = sh;
            sda_oe = 1'b1;
         end else begin
            mem[ptr] = sh;
            sda_oe = 1'b1;
         end
         idx = idx + 1;
      end else if (on && cnt == 9) begin
         cnt = 0;
         // Only the read address acknowledge leads into data; after that the wire stays free
         sda_oe = rd && idx == 1 && !mem[ptr][7];
      end else if (on && rd && idx > 0) begin
         sda_oe = !mem[ptr][7 - cnt];
      end
   end
endmodule
`default_nettype wire

// ==== test/sba_serial_byte_access_monitor.sv ====
// Purpose: Port-level checks of the serial byte access.
// Assumes: Read data may land on the strobe edge or one edge later.
// Notes:   Bound to every instance of the top module.
`timescale 1ns/1ps
`default_nettype none
`include "sba_map.svh"
module sba_serial_byte_access_monitor #(
   parameter int unsigned QTR_NORM = 208,
   parameter int unsigned QTR_FAST = 3
) (
   // Clock and reset
   input wire logic SYS_CLK,
   input wire logic RST,
   // Register port
   input wire logic [7:0] CFG_ADDR,
   input wire logic CFG_WR,
   input wire logic CFG_RD,
   input wire logic [7:0] CFG_RDATA,
   // Pin enables
   input wire logic SCL_OE,
   input wire logic SDA_OE
);
   localparam int LAUNCH_MAX = 4 * QTR_NORM + 4;
   localparam int QTR_MAX = QTR_NORM + 2;
   localparam int IDLE_MIN = 3 * QTR_NORM;
   int idle_cnt;
   int next_idle_cnt;
   logic launch;
   logic rd_csr;
   // ****************************************
   // Bus quiet time, saturating; a launch only counts once the last frame is surely over
   // ****************************************
   always_comb begin
      next_idle_cnt = idle_cnt;
      if (SCL_OE || SDA_OE) next_idle_cnt = 0;
      else if (idle_cnt < IDLE_MIN) next_idle_cnt = idle_cnt + 1;
   end
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) idle_cnt <= 0;
      else idle_cnt <= next_idle_cnt;
   end
   assign launch = CFG_WR && CFG_ADDR == `SBA_OFF_TARGET && idle_cnt >= IDLE_MIN;
   assign rd_csr = CFG_RD && CFG_ADDR == `SBA_OFF_CSR;
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (RST);
   property p_reset_quiet;
      $fell(RST) |-> !SCL_OE && !SDA_OE && CFG_RDATA == 8'h00;
   endproperty
   a_reset_quiet: assert property (p_reset_quiet)
      else $error("pins or read data not quiet after reset");
   property p_unmapped_zero;
      CFG_RD && (CFG_ADDR < `SBA_OFF_DATA || CFG_ADDR > `SBA_OFF_CSR) ##1 !CFG_RD ##1 !CFG_RD
         |-> CFG_RDATA == 8'h00;
   endproperty
   a_unmapped_zero: assert property (p_unmapped_zero)
      else $error("unmapped read returned nonzero");
   property p_rdata_hold;
      !CFG_RD ##1 !CFG_RD |=> $stable(CFG_RDATA);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold)
      else $error("read data moved without a read");
   property p_launch_start;
      launch |-> ##[1:LAUNCH_MAX] ($rose(SDA_OE) && !SCL_OE);
   endproperty
   a_launch_start: assert property (p_launch_start)
      else $error("target write did not start a frame");
   property p_busy_seen;
      launch ##2 rd_csr ##1 !CFG_RD ##1 !CFG_RD |-> CFG_RDATA[`SBA_CSR_BUSY_BIT];
   endproperty
   a_busy_seen: assert property (p_busy_seen)
      else $error("busy flag low during a frame");
   property p_start_then_clock;
      $rose(SDA_OE) && !SCL_OE |-> ##[1:QTR_MAX] $rose(SCL_OE);
   endproperty
   a_start_then_clock: assert property (p_start_then_clock)
      else $error("clock not pulled after start");
   property p_stop_quiet;
      $fell(SDA_OE) && !SCL_OE |=> (!SCL_OE && !SDA_OE) [*4];
   endproperty
   a_stop_quiet: assert property (p_stop_quiet)
      else $error("bus driven right after stop");
   property p_err_clear;
      rd_csr && idle_cnt >= IDLE_MIN ##3 rd_csr ##1 !CFG_RD ##1 !CFG_RD
         |-> !CFG_RDATA[`SBA_CSR_ERR_BIT];
   endproperty
   a_err_clear: assert property (p_err_clear)
      else $error("error flag survived a status read");
   c_launch: cover property (launch ##2 rd_csr);
   c_stop: cover property ($fell(SDA_OE) && !SCL_OE);
   c_error: cover property (rd_csr ##2 CFG_RDATA[`SBA_CSR_ERR_BIT]);
endmodule
bind sba_serial_byte_access sba_serial_byte_access_monitor #(
   .QTR_NORM(QTR_NORM),
   .QTR_FAST(QTR_FAST)
) u_mon (
   .SYS_CLK(SYS_CLK),
   .RST(RST),
   .CFG_ADDR(CFG_ADDR),
   .CFG_WR(CFG_WR),
   .CFG_RD(CFG_RD),
   .CFG_RDATA(CFG_RDATA),
   .SCL_OE(SCL_OE),
   .SDA_OE(SDA_OE)
);
`default_nettype wire

// ==== test/sba_serial_byte_access_tb.sv ====
// Purpose: Self-checking bench of the serial byte access with a byte memory on the wires.
// Assumes: Quarter of 4 clocks normally, 3 with the fast clock bit.
// Notes:   Status polls are OR-ed, since any status read clears the error flag.
`timescale 1ns/1ps
`default_nettype none
`include "sba_map.svh"
module sba_serial_byte_access_tb;
   typedef struct packed {logic [7:0] a; logic [7:0] w; logic [7:0] e;} sba_row_t;
   localparam logic [6:0] DEV = 7'h2A;
   logic SYS_CLK = 1'b0;
   logic RST = 1'b1;
   logic [7:0] CFG_ADDR = 8'h00;
   logic [7:0] CFG_WDATA = 8'h00;
   logic CFG_WR = 1'b0;
   logic CFG_RD = 1'b0;
   logic [7:0] CFG_RDATA;
   logic [7:0] rd_val;
   logic [7:0] poll_or;
   logic SCL_OE, SDA_OE, mem_oe, scl_out, sda_out;
   wire logic scl_w;
   wire logic sda_w;
   int error_cnt = 0;
   int checks_done = 0;
   sba_row_t rows [5] = '{'{8'hB0, 8'hA5, 8'hA5}, '{8'hB1, 8'h3C, 8'h3C},
      '{8'hB3, 8'hFF, 8'h84}, '{8'hB3, 8'h00, 8'h00}, '{8'hB5, 8'h77, 8'h00}};
   assign scl_w = !SCL_OE;
   assign sda_w = !(SDA_OE || mem_oe);
   always #10 SYS_CLK = !SYS_CLK;
   sba_serial_byte_access #(.QTR_NORM(4), .QTR_FAST(3)) u_dut (.SYS_CLK(SYS_CLK), .RST(RST),
      .CFG_ADDR(CFG_ADDR), .CFG_WR(CFG_WR), .CFG_RD(CFG_RD), .CFG_WDATA(CFG_WDATA),
      .CFG_RDATA(CFG_RDATA), .SCL_IN(scl_w), .SCL_OUT(scl_out), .SCL_OE(SCL_OE),
      .SDA_IN(sda_w), .SDA_OUT(sda_out), .SDA_OE(SDA_OE));
   sba_eeprom_model #(.DEV(DEV)) u_mem (.scl(scl_w), .sda(sda_w), .sda_oe(mem_oe));
   // ****************************************
   // Tasks
   // ****************************************
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      checks_done++;
      if (g !== e) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge SYS_CLK);
      #1;
      CFG_WR = 1'b1;
      CFG_ADDR = a;
      CFG_WDATA = d;
      @(posedge SYS_CLK);
      #1;
      CFG_WR = 1'b0;
   endtask
   // Waits one extra edge so either read-data timing is settled
   task automatic rd(input logic [7:0] a);
      @(posedge SYS_CLK);
      #1;
      CFG_RD = 1'b1;
      CFG_ADDR = a;
      @(posedge SYS_CLK);
      #1;
      CFG_RD = 1'b0;
      @(posedge SYS_CLK);
      #1;
      rd_val = CFG_RDATA;
   endtask
   task automatic wait_idle;
      int n;
      n = 0;
      rd(`SBA_OFF_CSR);
      poll_or = rd_val;
      while (rd_val[`SBA_CSR_BUSY_BIT] !== 1'b0 && n < 2000) begin
         rd(`SBA_OFF_CSR);
         poll_or = poll_or | rd_val;
         n++;
      end
      if (n >= 2000) chk("busy timeout", 8'h00, 8'hFF);
   endtask
   task automatic end_sim;
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   initial begin
      #200000;
      error_cnt++;
      end_sim();
   end
   // ****************************************
   // Sequence
   // ****************************************
   initial begin
      repeat (12) @(posedge SYS_CLK);
      #1;
      RST = 1'b0;
      for (int i = 0; i < 4; i++) begin
         rd(`SBA_OFF_DATA + 8'(i));
         chk("reset value", 8'h00, rd_val);
      end
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].w);
         rd(rows[i].a);
         chk("register", rows[i].e, rd_val);
      end
      wr(`SBA_OFF_DATA, 8'h5A);
      wr(`SBA_OFF_WORD, 8'h10);
      wr(`SBA_OFF_TARGET, {DEV, 1'b0});
      wait_idle();
      chk("write status", 8'h20, poll_or);
      chk("stored byte", 8'h5A, u_mem.mem[8'h10]);
      u_mem.mem[8'h20] = 8'hC3;
      wr(`SBA_OFF_DATA, 8'h00);
      wr(`SBA_OFF_TARGET, {DEV, 1'b1});
      wait_idle();
      rd(`SBA_OFF_DATA);
      chk("read byte", 8'h5A, rd_val);
      rd(`SBA_OFF_TARGET);
      chk("target", {DEV, 1'b1}, rd_val);
      // Word address 20h must not reach the bus, so the pointer stays at 10h
      // Data cleared first so a missing deposit shows
      wr(`SBA_OFF_DATA, 8'h00);
      wr(`SBA_OFF_CSR, 8'h84);
      wr(`SBA_OFF_WORD, 8'h20);
      wr(`SBA_OFF_TARGET, {DEV, 1'b1});
      wait_idle();
      chk("fast status", 8'hA4, poll_or);
      rd(`SBA_OFF_DATA);
      chk("address only read", 8'h5A, rd_val);
      wr(`SBA_OFF_CSR, 8'h00);
      wr(`SBA_OFF_TARGET, {~DEV, 1'b0});
      wait_idle();
      chk("error status", 8'h22, poll_or);
      rd(`SBA_OFF_CSR);
      chk("error cleared", 8'h00, rd_val);
      wr(`SBA_OFF_TARGET, {DEV, 1'b0});
      repeat (30) @(posedge SYS_CLK);
      #1;
      RST = 1'b1;
      repeat (3) @(posedge SYS_CLK);
      #1;
      RST = 1'b0;
      // Status too: a cut frame must leave busy and error low
      for (int i = 0; i < 4; i++) begin
         rd(`SBA_OFF_DATA + 8'(i));
         chk("mid reset", 8'h00, rd_val);
      end
      chk("pin levels", 8'h00, {6'h00, scl_out, sda_out});
      end_sim();
   end
endmodule
`default_nettype wire
